// File: fp_conv_params.svh
`ifndef FP_CONV_PARAMS_SVH
`define FP_CONV_PARAMS_SVH
// Notes on behaviour
// - Float to signed or unsigned word or long integer
// - Signed and unsigned integers to single
// - Word results sign-extended to full width
// - Unrepresentable results saturate, raise invalid
// - Conversions round by selected rounding mode
// - Zero integer converts to plus zero quietly
// - Valid ranges per integer destination format
// - Negative overflow gives destination minimum
// - Positive overflow or NaN gives maximum
// - Inexact when rounding changed value, invalid clear
// - Sign injection copies rs1, sign varies
// - Sign injection raises nothing, keeps NaNs
// - Float bits move unaltered to integer
// - Upper integer bits replicate sign bit
// - Compares write one or zero
// - Ordered compares flag any NaN invalid
// - Equality flags only signaling NaN
// - Any NaN operand gives zero result
// - Class bit order from minus infinity
// - Flags accrue sticky, never trap

// Instruction encoding
`define OPC_OP_FP 7'h53
`define FMT_S 2'h0
`define F5_SGNJ 5'h04
`define F5_CMP 5'h14
`define F5_F2I 5'h18
`define F5_I2F 5'h1A
`define F5_MVX_CLS 5'h1C
`define F5_MVW 5'h1E
`define INT_W 5'h00
`define INT_WU 5'h01
`define INT_L 5'h02
`define INT_LU 5'h03
`define MIN_SGNJ 3'h0
`define MIN_SGNJN 3'h1
`define MIN_SGNJX 3'h2
`define MIN_LE 3'h0
`define MIN_LT 3'h1
`define MIN_EQ 3'h2
`define MIN_MVX 3'h0
`define MIN_CLS 3'h1
`define MIN_MVW 3'h0
`define RM_RNE 3'h0
`define RM_RTZ 3'h1
`define RM_RDN 3'h2
`define RM_RUP 3'h3
`define RM_RMM 3'h4
`define RM_DYN 3'h7

// Conversion exponent thresholds and integer limits
`define F2I_EXP_BASE 8'h54
`define F2I_EXP_OVF 8'hBF
`define I2F_EXP_TOP 8'hBE
`define LIM_W_POS 65'h0_0000_0000_7FFF_FFFF
`define LIM_WU_POS 65'h0_0000_0000_FFFF_FFFF
`define LIM_L_POS 65'h0_7FFF_FFFF_FFFF_FFFF
`define LIM_LU_POS 65'h0_FFFF_FFFF_FFFF_FFFF
`define LIM_W_NEG 65'h0_0000_0000_8000_0000
`define LIM_L_NEG 65'h0_8000_0000_0000_0000

// Register map, flag field positions and reset values
`define OFS_FLAGS 8'h00
`define OFS_FRM 8'h04
`define OFS_CSR 8'h08
`define FLAG_NV_BIT 4
`define FLAG_NX_BIT 0
`define FLAGS_RST 5'h00
`define FRM_RST 3'h0

`endif

// File: fp_conv_pipe_model.sv
`timescale 1ns/1ps
`default_nettype none
`include "fp_conv_params.svh"
module pipe_model (
  input wire logic clk_i,
  output var fp_conv_pkg::op_req_t req_o
);
  initial req_o = '0;
  // One request; idle fields show inverted bits
  task automatic issue(input logic [4:0] f5, input logic [4:0] r2, input logic [2:0] f3,
                       input logic [31:0] fa, input logic [31:0] fb, input logic [63:0] xa);
    fp_conv_pkg::op_req_t r;
    r = {1'b1, `OPC_OP_FP, f5, `FMT_S, r2, f3, fa, fb, xa};
    @(posedge clk_i);
    req_o <= r;
    @(posedge clk_i);
    r = ~r;
    r.valid = 1'b0;
    req_o <= r;
  endtask : issue
endmodule : pipe_model
`default_nettype wire

// File: fp_conv_pkg.sv
`include "fp_conv_params.svh"
package fp_conv_pkg;

  typedef struct packed {
    logic valid;
    logic [6:0] opcode;
    logic [4:0] funct5;
    logic [1:0] fmt;
    logic [4:0] rs2_field;
    logic [2:0] funct3;
    logic [31:0] fa;
    logic [31:0] fb;
    logic [63:0] xa;
  } op_req_t;

  typedef struct packed {
    logic valid;
    logic to_int;
    logic illegal;
    logic nv;
    logic nx;
    logic [63:0] data;
  } op_resp_t;

  // Increment decision for a truncated magnitude
  function automatic logic round_up(input logic [2:0] rm, input logic sign,
                                    input logic lsb, input logic guard,
                                    input logic sticky);
    case (rm)
      `RM_RNE: return guard & (sticky | lsb);
      `RM_RTZ: return 1'b0;
      `RM_RDN: return sign & (guard | sticky);
      `RM_RUP: return ~sign & (guard | sticky);
      `RM_RMM: return guard;
      default: return 1'b0;
    endcase
  endfunction : round_up

endpackage : fp_conv_pkg

// File: fp_conv_props.sv
`timescale 1ns/1ps
`default_nettype none
`include "fp_conv_params.svh"
module fp_conv_props (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire fp_conv_pkg::op_req_t req_i,
  input wire fp_conv_pkg::op_resp_t resp_o
);
  wire logic base = req_i.valid && req_i.opcode == `OPC_OP_FP && req_i.fmt == `FMT_S;
  wire logic f3ok = req_i.funct3 <= 3'h2;
  wire logic sgnj = base && req_i.funct5 == `F5_SGNJ && f3ok;
  wire logic cmp = base && req_i.funct5 == `F5_CMP && f3ok;
  wire logic mv0 = req_i.rs2_field == 5'h00 && req_i.funct3 == `MIN_MVX;
  wire logic mvx = base && req_i.funct5 == `F5_MVX_CLS && mv0;
  wire logic cls = base && req_i.funct5 == `F5_MVX_CLS && req_i.rs2_field == 5'h00
    && req_i.funct3 == `MIN_CLS;
  wire logic mvw = base && req_i.funct5 == `F5_MVW && mv0;
  wire logic nan_a = &req_i.fa[30:23] && |req_i.fa[22:0];
  wire logic nan_b = &req_i.fb[30:23] && |req_i.fb[22:0];
  wire logic snan = (nan_a && !req_i.fa[22]) || (nan_b && !req_i.fb[22]);
  wire logic sgn = req_i.funct3 == `MIN_SGNJ ? req_i.fb[31] :
    req_i.funct3 == `MIN_SGNJN ? ~req_i.fb[31] : req_i.fa[31] ^ req_i.fb[31];
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  a_sgnj_sign: assert property (sgnj |=> resp_o.data == {32'h0, $past(sgn), $past(req_i.fa[30:0])})
    else $error("sign injection result wrong");
  a_sgnj_quiet: assert property (sgnj |=> !resp_o.nv && !resp_o.nx)
    else $error("sign injection raised a flag");
  a_mvx_copy: assert property (mvx |=> resp_o.data == {{32{$past(req_i.fa[31])}}, $past(req_i.fa)})
    else $error("float to integer move wrong");
  a_mvw_copy: assert property (mvw |=> resp_o.data == {32'h0, $past(req_i.xa[31:0])})
    else $error("integer to float move wrong");
  a_cmp_binary: assert property (cmp |=> resp_o.valid && resp_o.data[63:1] == 63'h0)
    else $error("compare result not one bit");
  a_cmp_nan_zero: assert property (cmp && (nan_a || nan_b) |=> resp_o.data == 64'h0)
    else $error("compare with NaN not zero");
  a_ord_nan_nv: assert property (cmp && req_i.funct3 != `MIN_EQ && (nan_a || nan_b) |=> resp_o.nv)
    else $error("ordered compare missed invalid");
  a_eq_snan_nv: assert property (cmp && req_i.funct3 == `MIN_EQ |=> resp_o.nv == $past(snan))
    else $error("equality invalid flag wrong");
  a_class_onehot: assert property (cls |=> $onehot(resp_o.data[9:0]) && resp_o.data[63:10] == 54'h0
    && !resp_o.nv && !resp_o.nx)
    else $error("class mask not one-hot");
  a_flag_excl: assert property (resp_o.valid |-> !(resp_o.nv && resp_o.nx))
    else $error("inexact raised with invalid");
  a_ack_pulse: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus ack not a single pulse");
  c_cmp: cover property (cmp ##1 resp_o.nv);
  c_cls: cover property (cls);
  c_sgnj: cover property (sgnj);
  c_bus: cover property (wb_ack_o);
endmodule : fp_conv_props
bind fp_conv_unit fp_conv_props u_props (.clk_i(clk_i), .rst_n_i(rst_n_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .req_i(req_i), .resp_o(resp_o));
`default_nettype wire

// File: fp_conv_unit.sv
`timescale 1ns/1ps
`default_nettype none
`include "fp_conv_params.svh"
module fp_conv_unit #(
  parameter int XLEN = 64
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire fp_conv_pkg::op_req_t req_i,
  output var fp_conv_pkg::op_resp_t resp_o
);

  function automatic logic [63:0] sext32(input logic [31:0] v);
    return {{32{v[31]}}, v};
  endfunction : sext32

  function automatic logic f_nan(input logic [31:0] x);
    return (&x[30:23]) && (x[22:0] != 23'h000000);
  endfunction : f_nan

  function automatic logic f_snan(input logic [31:0] x);
    return f_nan(x) && !x[22];
  endfunction : f_snan

  function automatic logic f_both_zero(input logic [31:0] a, input logic [31:0] b);
    return (a[30:0] == 31'h0) && (b[30:0] == 31'h0);
  endfunction : f_both_zero

  function automatic logic f_lt(input logic [31:0] a, input logic [31:0] b);
    if (f_both_zero(a, b)) begin
      return 1'b0;
    end
    if (a[31] != b[31]) begin
      return a[31];
    end
    if (!a[31]) begin
      return a[30:0] < b[30:0];
    end
    return a[30:0] > b[30:0];
  endfunction : f_lt

  function automatic logic f_eq(input logic [31:0] a, input logic [31:0] b);
    return (a == b) || f_both_zero(a, b);
  endfunction : f_eq

  // Registers
  logic [4:0] flags;
  logic [2:0] frm;

  // Decode
  wire logic is_fp;
  wire logic [2:0] f3;
  wire logic [4:0] f5;
  wire logic [4:0] r2;
  wire logic [2:0] eff_rm;
  wire logic rm_ok;
  wire logic long_ok;
  wire logic int_fmt_ok;
  wire logic op_sgnj;
  wire logic op_cmp;
  wire logic op_f2i;
  wire logic op_i2f;
  wire logic op_mvx;
  wire logic op_cls;
  wire logic op_mvw;
  wire logic op_any;

  assign f3 = req_i.funct3;
  assign f5 = req_i.funct5;
  assign r2 = req_i.rs2_field;
  assign is_fp = req_i.valid && (req_i.opcode == `OPC_OP_FP) && (req_i.fmt == `FMT_S);
  assign eff_rm = (f3 == `RM_DYN) ? frm : f3;
  assign rm_ok = (eff_rm <= `RM_RMM);
  assign long_ok = (XLEN == 64);
  assign int_fmt_ok = (r2 == `INT_W) || (r2 == `INT_WU) ||
                      (long_ok && ((r2 == `INT_L) || (r2 == `INT_LU)));
  assign op_sgnj = is_fp && (f5 == `F5_SGNJ) && (f3 <= `MIN_SGNJX);
  assign op_cmp = is_fp && (f5 == `F5_CMP) && (f3 <= `MIN_EQ);
  assign op_f2i = is_fp && (f5 == `F5_F2I) && int_fmt_ok && rm_ok;
  assign op_i2f = is_fp && (f5 == `F5_I2F) && int_fmt_ok && rm_ok;
  assign op_mvx = is_fp && (f5 == `F5_MVX_CLS) && (f3 == `MIN_MVX) && (r2 == 5'h00);
  assign op_cls = is_fp && (f5 == `F5_MVX_CLS) && (f3 == `MIN_CLS) && (r2 == 5'h00);
  assign op_mvw = is_fp && (f5 == `F5_MVW) && (f3 == `MIN_MVW) && (r2 == 5'h00);
  assign op_any = op_sgnj | op_cmp | op_f2i | op_i2f | op_mvx | op_cls | op_mvw;

  // Float to integer
  wire logic cv_word;
  wire logic cv_uns;
  wire logic f2i_sign;
  wire logic [7:0] f2i_e;
  wire logic [7:0] f2i_eff_e;
  wire logic [23:0] f2i_sig;
  wire logic f2i_tiny;
  wire logic f2i_big;
  wire logic f2i_nan;
  wire logic [7:0] f2i_sh;
  wire logic [129:0] f2i_wide;
  wire logic [63:0] f2i_int;
  wire logic f2i_guard;
  wire logic f2i_sticky;
  wire logic f2i_inc;
  wire logic [64:0] f2i_mag;
  wire logic [64:0] lim_pos;
  wire logic [64:0] lim_neg;
  wire logic f2i_ovf;
  wire logic [63:0] max_pat;
  wire logic [63:0] min_pat;
  wire logic [63:0] f2i_val;
  wire logic [63:0] f2i_fit;
  wire logic [63:0] f2i_res;
  wire logic f2i_nx;

  assign cv_word = ~r2[1];
  assign cv_uns = r2[0];
  assign f2i_sign = req_i.fa[31];
  assign f2i_e = req_i.fa[30:23];
  assign f2i_eff_e = (f2i_e == 8'h00) ? 8'h01 : f2i_e;
  assign f2i_sig = {f2i_e != 8'h00, req_i.fa[22:0]};
  assign f2i_nan = f_nan(req_i.fa);
  assign f2i_tiny = (f2i_eff_e < `F2I_EXP_BASE);
  assign f2i_big = (f2i_e >= `F2I_EXP_OVF);
  assign f2i_sh = f2i_eff_e - `F2I_EXP_BASE;
  // Fixed point: 64 integer bits over 66 fraction bits
  assign f2i_wide = {106'h0, f2i_sig} << f2i_sh;
  assign f2i_int = f2i_tiny ? 64'h0 : f2i_wide[129:66];
  assign f2i_guard = f2i_tiny ? 1'b0 : f2i_wide[65];
  assign f2i_sticky = f2i_tiny ? (f2i_sig != 24'h000000) : (|f2i_wide[64:0]);
  assign f2i_inc = fp_conv_pkg::round_up(eff_rm, f2i_sign, f2i_int[0],
                                         f2i_guard, f2i_sticky);
  assign f2i_mag = {1'b0, f2i_int} + {64'h0, f2i_inc};
  assign lim_pos = cv_word ? (cv_uns ? `LIM_WU_POS : `LIM_W_POS)
                           : (cv_uns ? `LIM_LU_POS : `LIM_L_POS);
  assign lim_neg = cv_uns ? 65'h0 : (cv_word ? `LIM_W_NEG : `LIM_L_NEG);
  assign f2i_ovf = f2i_nan | f2i_big |
                   (f2i_sign ? (f2i_mag > lim_neg) : (f2i_mag > lim_pos));
  assign max_pat = cv_word ? sext32(lim_pos[31:0]) : lim_pos[63:0];
  assign min_pat = cv_word ? sext32(lim_neg[31:0]) : lim_neg[63:0];
  assign f2i_val = f2i_sign ? 64'h0 - f2i_mag[63:0] : f2i_mag[63:0];
  assign f2i_fit = cv_word ? sext32(f2i_val[31:0]) : f2i_val;
  // NaN saturates high whatever its sign
  assign f2i_res = !f2i_ovf ? f2i_fit :
                   ((f2i_nan | ~f2i_sign) ? max_pat : min_pat);
  assign f2i_nx = ~f2i_ovf & (f2i_guard | f2i_sticky);

  // Integer to float
  wire logic [31:0] i2f_res;
  wire logic i2f_nx;

  fp_int_to_single u_i2f (
    .int_i(req_i.xa),
    .signed_i(~cv_uns),
    .word_i(cv_word),
    .rm_i(eff_rm),
    .res_o(i2f_res),
    .nx_o(i2f_nx)
  );

  // Sign injection
  wire logic sgnj_sign;
  wire logic [31:0] sgnj_res;

  assign sgnj_sign = (f3 == `MIN_SGNJ) ? req_i.fb[31] :
                     (f3 == `MIN_SGNJN) ? ~req_i.fb[31] :
                     (req_i.fa[31] ^ req_i.fb[31]);
  assign sgnj_res = {sgnj_sign, req_i.fa[30:0]};

  // Compare
  wire logic nan_any;
  wire logic snan_any;
  wire logic cmp_lt;
  wire logic cmp_eq;
  wire logic cmp_bit;
  wire logic cmp_nv;

  assign nan_any = f_nan(req_i.fa) | f_nan(req_i.fb);
  assign snan_any = f_snan(req_i.fa) | f_snan(req_i.fb);
  assign cmp_lt = f_lt(req_i.fa, req_i.fb);
  assign cmp_eq = f_eq(req_i.fa, req_i.fb);
  assign cmp_bit = nan_any ? 1'b0 :
                   (f3 == `MIN_EQ) ? cmp_eq :
                   (f3 == `MIN_LT) ? cmp_lt : (cmp_lt | cmp_eq);
  assign cmp_nv = (f3 == `MIN_EQ) ? snan_any : nan_any;

  // Classify
  wire logic cl_sign;
  wire logic cl_emax;
  wire logic cl_ezero;
  wire logic cl_mzero;
  wire logic cl_inf;
  wire logic cl_norm;
  wire logic cl_sub;
  wire logic cl_zero;
  wire logic [9:0] cls_mask;

  assign cl_sign = req_i.fa[31];
  assign cl_emax = &req_i.fa[30:23];
  assign cl_ezero = (req_i.fa[30:23] == 8'h00);
  assign cl_mzero = (req_i.fa[22:0] == 23'h000000);
  assign cl_inf = cl_emax & cl_mzero;
  assign cl_norm = ~cl_emax & ~cl_ezero;
  assign cl_sub = cl_ezero & ~cl_mzero;
  assign cl_zero = cl_ezero & cl_mzero;
  assign cls_mask = {f_nan(req_i.fa) & req_i.fa[22],
                     f_snan(req_i.fa),
                     ~cl_sign & cl_inf,
                     ~cl_sign & cl_norm,
                     ~cl_sign & cl_sub,
                     ~cl_sign & cl_zero,
                     cl_sign & cl_zero,
                     cl_sign & cl_sub,
                     cl_sign & cl_norm,
                     cl_sign & cl_inf};

  // Result selection
  wire logic new_nv;
  wire logic new_nx;
  wire logic to_int;
  wire logic [63:0] res_data;
  wire fp_conv_pkg::op_resp_t next_resp;

  // Only conversions and compares raise flags
  assign new_nv = (op_f2i & f2i_ovf) | (op_cmp & cmp_nv);
  assign new_nx = (op_f2i & f2i_nx) | (op_i2f & i2f_nx);
  assign to_int = op_f2i | op_cmp | op_mvx | op_cls;
  assign res_data = op_f2i ? f2i_res :
                    op_i2f ? {32'h0000_0000, i2f_res} :
                    op_mvx ? sext32(req_i.fa) :
                    op_cls ? {54'h0, cls_mask} :
                    op_cmp ? {63'h0, cmp_bit} :
                    op_sgnj ? {32'h0000_0000, sgnj_res} :
                    op_mvw ? {32'h0000_0000, req_i.xa[31:0]} :
                    64'h0;
  assign next_resp = {req_i.valid, to_int, req_i.valid & ~op_any,
                      new_nv, new_nx, res_data};

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      resp_o <= '0;
    end else begin
      resp_o <= next_resp;
    end
  end

  // Wishbone slave
  wire logic wb_req;
  wire logic wr_fire;
  wire logic hit_flags;
  wire logic hit_frm;
  wire logic hit_csr;
  wire logic [31:0] rd_data;
  wire logic [4:0] ev_flags;
  wire logic [4:0] next_flags;
  wire logic [2:0] next_frm;

  assign wb_req = wb_cyc_i & wb_stb_i;
  // Writes land on the edge that sees ack high
  assign wr_fire = wb_req & wb_we_i & wb_ack_o & wb_sel_i[0];
  assign hit_flags = (wb_adr_i == `OFS_FLAGS);
  assign hit_frm = (wb_adr_i == `OFS_FRM);
  assign hit_csr = (wb_adr_i == `OFS_CSR);
  assign rd_data = hit_flags ? {27'h0, flags} :
                   hit_frm ? {29'h0, frm} :
                   hit_csr ? {24'h0, frm, flags} : 32'h0000_0000;
  assign ev_flags = (5'(new_nv) << `FLAG_NV_BIT) | (5'(new_nx) << `FLAG_NX_BIT);
  // New events win over a clearing write
  assign next_flags = ((wr_fire & (hit_flags | hit_csr)) ? wb_dat_i[4:0] : flags)
                      | ev_flags;
  assign next_frm = (wr_fire & hit_frm) ? wb_dat_i[2:0] :
                    (wr_fire & hit_csr) ? wb_dat_i[7:5] : frm;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      flags <= `FLAGS_RST;
      frm <= `FRM_RST;
    end else begin
      flags <= next_flags;
      frm <= next_frm;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_req & ~wb_ack_o;
      wb_dat_o <= rd_data;
    end
  end

endmodule : fp_conv_unit
`default_nettype wire

// File: fp_int_to_single.sv
`timescale 1ns/1ps
`default_nettype none
`include "fp_conv_params.svh"
module fp_int_to_single (
  input wire logic [63:0] int_i,
  input wire logic signed_i,
  input wire logic word_i,
  input wire logic [2:0] rm_i,
  output logic [31:0] res_o,
  output logic nx_o
);

  function automatic logic [5:0] lead_zeros(input logic [63:0] v);
    logic [5:0] n;
    logic found;
    n = 6'h00;
    found = 1'b0;
    for (int i = 63; i >= 0; i--) begin
      if (!found && v[i]) begin
        found = 1'b1;
        n = 6'(63 - i);
      end
    end
    return n;
  endfunction : lead_zeros

  wire logic [63:0] src;
  wire logic neg;
  wire logic [63:0] mag;
  wire logic [5:0] lz;
  wire logic [63:0] norm;
  wire logic guard;
  wire logic sticky;
  wire logic inc;
  wire logic [24:0] rounded;
  wire logic [7:0] expo;
  wire logic [22:0] frac;
  wire logic zero;

  // Word sources widened by their own signedness
  assign src = word_i ? (signed_i ? {{32{int_i[31]}}, int_i[31:0]}
                                  : {32'h0000_0000, int_i[31:0]}) : int_i;
  assign neg = signed_i & src[63];
  assign mag = neg ? 64'h0 - src : src;
  assign lz = lead_zeros(mag);
  assign norm = mag << lz;
  assign guard = norm[39];
  assign sticky = |norm[38:0];
  assign inc = fp_conv_pkg::round_up(rm_i, neg, norm[40], guard, sticky);
  assign rounded = {1'b0, norm[63:40]} + {24'h000000, inc};
  assign expo = `I2F_EXP_TOP - {2'h0, lz} + {7'h00, rounded[24]};
  assign frac = rounded[24] ? 23'h000000 : rounded[22:0];
  assign zero = (mag == 64'h0);
  assign res_o = zero ? 32'h0000_0000 : {neg, expo, frac};
  assign nx_o = ~zero & (guard | sticky);

endmodule : fp_int_to_single
`default_nettype wire

// File: test_sp_float_convert_move_compare_classify.sv
`timescale 1ns/1ps
`default_nettype none
`include "fp_conv_params.svh"
`define CHECK_EQ(what, exp, got) begin num_checks++; if ((got) !== (exp)) begin n_fail++; \
  $display("wrong value %s expected %h seen %h", what, exp, got); end end
module test_sp_float_convert_move_compare_classify;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic [31:0] q;
  logic ack;
  fp_conv_pkg::op_req_t req;
  fp_conv_pkg::op_resp_t resp;
  int n_fail = 0;
  int num_checks = 0;
  always #4 clk_i = ~clk_i;
  pipe_model u_pipe (.clk_i(clk_i), .req_o(req));
  fp_conv_unit #(.XLEN(64)) dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .req_i(req), .resp_o(resp));
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : give_verdict
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    i = 0;
    do begin
      @(posedge clk_i);
      i++;
    end while (ack !== 1'b1 && i < 20);
    q = rdat;
    if (i >= 20) n_fail++;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : wb
  task automatic op(input logic [4:0] f5, input logic [4:0] r2, input logic [2:0] f3,
                    input logic [31:0] fa, input logic [31:0] fb, input logic [63:0] xa,
                    input logic [63:0] ed, input logic env, input logic enx);
    u_pipe.issue(f5, r2, f3, fa, fb, xa);
    @(negedge clk_i);
    `CHECK_EQ("valid", 1'b1, resp.valid)
    `CHECK_EQ("data", ed, resp.data)
    `CHECK_EQ("invalid", env, resp.nv)
    `CHECK_EQ("inexact", enx, resp.nx)
    `CHECK_EQ("to int", (f5 == `F5_CMP || f5 == `F5_F2I || f5 == `F5_MVX_CLS), resp.to_int)
    `CHECK_EQ("illegal", 1'b0, resp.illegal)
  endtask : op
  task automatic bad_op(input logic [2:0] f3);
    u_pipe.issue(`F5_F2I, `INT_W, f3, 32'h3FC00000, 32'h0, 64'h0);
    @(negedge clk_i);
    `CHECK_EQ("bad valid", 1'b1, resp.valid)
    `CHECK_EQ("bad illegal", 1'b1, resp.illegal)
    `CHECK_EQ("bad data", 64'h0, resp.data)
    `CHECK_EQ("bad flags", 2'b00, {resp.nv, resp.nx})
  endtask : bad_op
  task automatic t_illegal();
    bad_op(3'h5);
    bad_op(3'h6);
    wb(1'b1, `OFS_FRM, 32'h5);
    bad_op(`RM_DYN);
    wb(1'b1, `OFS_FRM, 32'h0);
    $display("test illegal done");
  endtask : t_illegal
  task automatic t_f2i();
    logic [63:0] e [5] = '{64'h2, 64'h1, 64'h1, 64'h2, 64'h2};
    wb(1'b0, `OFS_FLAGS, 32'h0);
    `CHECK_EQ("flags reset", 32'h0, q)
    wb(1'b0, 8'h40, 32'h0);
    `CHECK_EQ("unmapped", 32'h0, q)
    for (int i = 0; i < 5; i++) op(`F5_F2I, `INT_W, i, 32'h3FC00000, 0, 0, e[i], 0, 1);
    wb(1'b1, `OFS_FRM, 32'h1);
    op(`F5_F2I, `INT_W, `RM_DYN, 32'h3FC00000, 0, 0, 64'h1, 0, 1);
    op(`F5_F2I, `INT_L, `RM_RNE, 32'h40000000, 0, 0, 64'h2, 0, 0);
    $display("test f2i done");
  endtask : t_f2i
  task automatic t_sat();
    op(`F5_F2I, `INT_W, 0, 32'h7F800000, 0, 0, 64'h7FFFFFFF, 1, 0);
    op(`F5_F2I, `INT_W, 0, 32'h4F000000, 0, 0, 64'h7FFFFFFF, 1, 0);
    op(`F5_F2I, `INT_W, 0, 32'hFF800000, 0, 0, 64'hFFFFFFFF80000000, 1, 0);
    op(`F5_F2I, `INT_WU, 0, 32'h7FC00000, 0, 0, 64'hFFFFFFFFFFFFFFFF, 1, 0);
    op(`F5_F2I, `INT_LU, 0, 32'hBF800000, 0, 0, 64'h0, 1, 0);
    op(`F5_F2I, `INT_L, 0, 32'h5F000000, 0, 0, 64'h7FFFFFFFFFFFFFFF, 1, 0);
    op(`F5_F2I, `INT_L, 0, 32'hDF000000, 0, 0, 64'h8000000000000000, 0, 0);
    op(`F5_F2I, `INT_LU, 0, 32'hFF800000, 0, 0, 64'h0, 1, 0);
    $display("test saturation done");
  endtask : t_sat
  task automatic t_i2f();
    op(`F5_I2F, `INT_W, 0, 0, 0, 64'h0, 64'h0, 0, 0);
    op(`F5_I2F, `INT_WU, 0, 0, 0, 64'hFFFFFFFF, 64'h4F800000, 0, 1);
    op(`F5_I2F, `INT_WU, 1, 0, 0, 64'hFFFFFFFF, 64'h4F7FFFFF, 0, 1);
    op(`F5_I2F, `INT_L, 0, 0, 0, 64'hFFFFFFFFFFFFFFFF, 64'hBF800000, 0, 0);
    op(`F5_I2F, `INT_LU, 0, 0, 0, 64'hFFFFFFFFFFFFFFFF, 64'h5F800000, 0, 1);
    $display("test i2f done");
  endtask : t_i2f
  task automatic t_sgnj_mv();
    logic [63:0] e [3] = '{64'h7FA00001, 64'hFFA00001, 64'hFFA00001};
    for (int i = 0; i < 3; i++) op(`F5_SGNJ, 0, i, 32'hFFA00001, 0, 0, e[i], 0, 0);
    op(`F5_MVX_CLS, 0, `MIN_MVX, 32'h80000001, 0, 0, 64'hFFFFFFFF80000001, 0, 0);
    op(`F5_MVX_CLS, 0, `MIN_MVX, 32'h7F800001, 0, 0, 64'h7F800001, 0, 0);
    op(`F5_MVW, 0, `MIN_MVW, 0, 0, 64'h123456787F800001, 64'h7F800001, 0, 0);
    $display("test sgnj and moves done");
  endtask : t_sgnj_mv
  task automatic t_cmp();
    op(`F5_CMP, 0, `MIN_EQ, 32'h3F800000, 32'h3F800000, 0, 64'h1, 0, 0);
    op(`F5_CMP, 0, `MIN_LT, 32'h3F800000, 32'h40000000, 0, 64'h1, 0, 0);
    op(`F5_CMP, 0, `MIN_LT, 32'h40000000, 32'h3F800000, 0, 64'h0, 0, 0);
    op(`F5_CMP, 0, `MIN_LE, 32'h3F800000, 32'h3F800000, 0, 64'h1, 0, 0);
    op(`F5_CMP, 0, `MIN_LE, 32'h7FC00000, 32'h3F800000, 0, 64'h0, 1, 0);
    op(`F5_CMP, 0, `MIN_EQ, 32'h7FC00000, 32'h7FC00000, 0, 64'h0, 0, 0);
    op(`F5_CMP, 0, `MIN_EQ, 32'h3F800000, 32'h7F800001, 0, 64'h0, 1, 0);
    $display("test compare done");
  endtask : t_cmp
  task automatic t_class();
    logic [31:0] v [10] = '{32'hFF800000, 32'hBF800000, 32'h80000001, 32'h80000000, 32'h0,
      32'h1, 32'h3F800000, 32'h7F800000, 32'h7F800001, 32'h7FC00000};
    for (int i = 0; i < 10; i++) op(`F5_MVX_CLS, 0, `MIN_CLS, v[i], 0, 0, 64'h1 << i, 0, 0);
    $display("test class done");
  endtask : t_class
  task automatic t_flags();
    wb(1'b0, `OFS_CSR, 32'h0);
    `CHECK_EQ("csr sticky", 32'h31, q)
    wb(1'b1, `OFS_FLAGS, 32'h0);
    op(`F5_SGNJ, 0, 0, 32'h7FA00001, 0, 0, 64'h7FA00001, 0, 0);
    wb(1'b0, `OFS_FLAGS, 32'h0);
    `CHECK_EQ("flags cleared", 32'h0, q)
    op(`F5_F2I, `INT_W, 0, 32'h3FC00000, 0, 0, 64'h2, 0, 1);
    op(`F5_CMP, 0, `MIN_LT, 32'h7FC00000, 0, 0, 64'h0, 1, 0);
    wb(1'b0, `OFS_FLAGS, 32'h0);
    `CHECK_EQ("flags accrued", 32'h11, q)
    $display("test flags done");
  endtask : t_flags
  initial begin
    repeat (5000) @(posedge clk_i);
    n_fail++;
    give_verdict();
  end
  initial begin
    repeat (12) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
    t_f2i();
    t_sat();
    t_i2f();
    t_sgnj_mv();
    t_cmp();
    t_class();
    t_flags();
    t_illegal();
    give_verdict();
  end
endmodule : test_sp_float_convert_move_compare_classify
`default_nettype wire
